// ### src/l2dc_pkg.sv
package l2dc_pkg;

	// ----------------------------------------------------------------
	// array geometry
	// ----------------------------------------------------------------
	localparam int unsigned SUBARRAYS  = 4;
	localparam int unsigned ROWS       = 64;
	localparam int unsigned ROW_W      = 6;
	localparam int unsigned WORD_W     = 16;
	localparam int unsigned MASK_W     = 8;
	localparam int unsigned GROUP_ROWS = ROWS / MASK_W;
	localparam int unsigned INSTANCES  = 2;
	localparam int unsigned CORES      = 8;
	localparam int unsigned STORE_W    = CORES;
	localparam int unsigned EVICT_W    = 32;
	localparam int unsigned EVICT_I_W  = 16;

	// ----------------------------------------------------------------
	// entry field layout
	// ----------------------------------------------------------------
	localparam int unsigned IDX_LSB    = 0;
	localparam int unsigned IDX_W      = 9;
	localparam int unsigned L2WAY_LSB  = 9;
	localparam int unsigned L2WAY_W    = 4;
	localparam int unsigned KEY_BIT    = 13;
	localparam int unsigned CMP_MSB    = 13;
	localparam int unsigned PAR_BIT    = 14;
	localparam int unsigned VLD_BIT    = 15;
	localparam logic [WORD_W-1:0] WORD_RST = 16'h0000;

	// ----------------------------------------------------------------
	// request address field (address bits 10:4)
	// ----------------------------------------------------------------
	localparam int unsigned ADDR_W     = 7;
	localparam int unsigned COL_MSB    = 6;
	localparam int unsigned COL_LSB    = 5;
	localparam int unsigned A5_BIT     = 1;
	localparam int unsigned A4_BIT     = 0;

	typedef enum logic [2:0] {
		L2DC_NOP,
		L2DC_UPDATE,
		L2DC_STORE_CAM,
		L2DC_EVICT_CAM,
		L2DC_READ,
		L2DC_INVAL
	} l2dc_op_e;

	typedef struct packed {
		l2dc_op_e             op;
		logic [ADDR_W-1:0]    addr;
		logic [2:0]           requesting_core_number;
		logic [2:0]           repl_way;
		logic [IDX_W-1:0]     l2_index;
		logic [L2WAY_W-1:0]   l2_way;
		logic                 parity;
	} l2dc_req_s;

	typedef struct packed {
		logic       hit;
		logic [2:0] way;
	} l2dc_line_s;

endpackage

// ### src/l2dc_cam.sv
`timescale 1ns/1ps
module l2dc_cam (
	input  wire logic                                        sys_clk,
	input  wire logic                                        srst,
	input  wire logic                                        ce,
	input  wire logic [l2dc_pkg::SUBARRAYS-1:0]              rd_en,
	input  wire logic [l2dc_pkg::SUBARRAYS-1:0]              wr_en,
	input  wire logic [l2dc_pkg::SUBARRAYS-1:0]              cam_en,
	input  wire logic [l2dc_pkg::SUBARRAYS-1:0]              force_hit,
	input  wire logic [l2dc_pkg::ROW_W-1:0]                  sub_array_row_address,
	input  wire logic [l2dc_pkg::WORD_W-1:0]                 sub_array_write_compare_word,
	input  wire logic [l2dc_pkg::SUBARRAYS-1:0][l2dc_pkg::MASK_W-1:0] last_match_clear_mask,
	input  wire logic [1:0]                                  warm_rst,
	output logic      [l2dc_pkg::ROWS-1:0]                   row_hit,
	output logic      [l2dc_pkg::SUBARRAYS-1:0][l2dc_pkg::WORD_W-1:0] sub_array_read_word
);
	localparam int unsigned S = l2dc_pkg::SUBARRAYS;
	localparam int unsigned R = l2dc_pkg::ROWS;

	logic [l2dc_pkg::VLD_BIT-1:0] mem_r [S][R];
	logic [S-1:0][R-1:0]          valid_r;
	logic [S-1:0][R-1:0]          last_hit_r;
	logic [S-1:0][R-1:0]          hit;
	logic [S-1:0][R-1:0]          inv_bits;
	logic [R-1:0]                 row_hit_nxt;

	// ----------------------------------------------------------------
	// compare on bits 13:0: index, way and key bit 13
	// ----------------------------------------------------------------
	always_comb begin
		row_hit_nxt = '0;
		for (int s = 0; s < S; s++) begin
			for (int r = 0; r < R; r++) begin
				if (force_hit[s]) begin
					hit[s][r] = sub_array_write_compare_word[l2dc_pkg::KEY_BIT];
				end else begin
					hit[s][r] = valid_r[s][r] && (mem_r[s][r][l2dc_pkg::CMP_MSB:0] ==
						sub_array_write_compare_word[l2dc_pkg::CMP_MSB:0]);
				end
				inv_bits[s][r] = last_hit_r[s][r] &
					last_match_clear_mask[s][r / l2dc_pkg::GROUP_ROWS];
			end
			if (cam_en[s]) begin
				row_hit_nxt = row_hit_nxt | hit[s];
			end
		end
	end

	// ----------------------------------------------------------------
	// storage
	// ----------------------------------------------------------------
	always_ff @(posedge sys_clk) begin
		if (ce) begin
			for (int s = 0; s < S; s++) begin
				if (wr_en[s]) begin
					mem_r[s][sub_array_row_address] <=
						sub_array_write_compare_word[l2dc_pkg::VLD_BIT-1:0];
				end
			end
		end
	end

	always_ff @(posedge sys_clk) begin
		if (srst) begin
			valid_r <= '0;
		end else if (ce) begin
			for (int s = 0; s < S; s++) begin
				if (warm_rst[s / 2]) begin
					valid_r[s] <= '0;
				end else begin
					valid_r[s] <= valid_r[s] & ~inv_bits[s];
					if (wr_en[s]) begin
						valid_r[s][sub_array_row_address] <=
							sub_array_write_compare_word[l2dc_pkg::VLD_BIT];
					end
				end
			end
		end
	end

	always_ff @(posedge sys_clk) begin
		if (srst) begin
			last_hit_r <= '0;
		end else if (ce) begin
			for (int s = 0; s < S; s++) begin
				if (cam_en[s]) begin
					last_hit_r[s] <= hit[s];
				end
			end
		end
	end

	always_ff @(posedge sys_clk) begin
		if (srst) begin
			row_hit <= '0;
		end else if (ce) begin
			row_hit <= row_hit_nxt;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (srst) begin
			sub_array_read_word <= '0;
		end else if (ce) begin
			for (int s = 0; s < S; s++) begin
				if (rd_en[s]) begin
					sub_array_read_word[s] <= {valid_r[s][sub_array_row_address],
						mem_r[s][sub_array_row_address]};
				end
			end
		end
	end

endmodule // l2dc_cam

// ### src/l2dc_dir.sv
`timescale 1ns/1ps
// Overview of operation
// - I-side: 16 panels, row {a5,way2}, column a10:9
// - I-side panel: 32 entries by {core, way1:0}
// - fetch hit writes one I-side entry
// - store/exclusivity: two I-panels, one line per core
// - I-side eviction: one column, 16-line vector
// - entry holds index, way, parity, valid
// - compare index and way, not parity/valid
// - D-side: 16 panels, row a5:4, column a10:9
// - load hit writes one D-side entry
// - store/exclusivity: one D-panel, 2-bit way
// - D-side eviction: one column, 32-line vector
// - array: 64 rows of four 16-bit words
// - one read/write and one write/compare port
// - read, write, compare take one cycle
// - invalidate clears last matched entries, one cycle
// - 8-bit mask selects last-match rows to clear
// - forced match reports compare word bit 13
// - two warm resets clear valid bits
module l2dc_dir #(
	parameter bit IS_ICACHE = 1'b1
) (
	input  wire logic                                   sys_clk,
	input  wire logic                                   srst,
	input  wire logic                                   ce,
	input  wire logic                                   req_valid,
	input  wire l2dc_pkg::l2dc_req_s                    req,
	input  wire logic [l2dc_pkg::MASK_W-1:0]            last_match_clear_mask,
	input  wire logic                                   force_hit,
	input  wire logic [1:0]                             warm_rst,
	output logic                                        result_valid,
	output l2dc_pkg::l2dc_line_s [l2dc_pkg::STORE_W-1:0] store_vec,
	output l2dc_pkg::l2dc_line_s [l2dc_pkg::EVICT_W-1:0] evict_vec,
	output logic [l2dc_pkg::WORD_W-1:0]                 sub_array_read_word
);
	localparam int unsigned S = l2dc_pkg::SUBARRAYS;
	localparam int unsigned R = l2dc_pkg::ROWS;
	localparam int unsigned N = l2dc_pkg::INSTANCES;

	l2dc_pkg::l2dc_op_e                 op;
	logic [1:0]                         col;
	logic                               a5;
	logic                               a4;
	logic [l2dc_pkg::ROW_W-1:0]         row;
	logic [l2dc_pkg::WORD_W-1:0]        word;
	logic [S-1:0]                       col_sel;
	logic [N-1:0][S-1:0]                rd_en;
	logic [N-1:0][S-1:0]                wr_en;
	logic [N-1:0][S-1:0]                cam_en;
	logic [S-1:0][l2dc_pkg::MASK_W-1:0] mask;
	logic [N-1:0][R-1:0]                hit_w;
	logic [N-1:0][S-1:0][l2dc_pkg::WORD_W-1:0] rd_w;

	l2dc_pkg::l2dc_op_e                 op_r;
	logic                               a5_r;
	logic                               a4_r;
	logic [1:0]                         col_r;

	logic [l2dc_pkg::STORE_W-1:0][7:0]  store_cand;
	logic [l2dc_pkg::EVICT_W-1:0][7:0]  evict_cand;
	l2dc_pkg::l2dc_line_s [l2dc_pkg::STORE_W-1:0] store_nxt;
	l2dc_pkg::l2dc_line_s [l2dc_pkg::EVICT_W-1:0] evict_nxt;

	function automatic l2dc_pkg::l2dc_line_s first_hit(input logic [7:0] v);
		l2dc_pkg::l2dc_line_s res;
		res = '0;
		for (int k = 7; k >= 0; k--) begin
			if (v[k]) begin
				res.hit = 1'b1;
				res.way = 3'(k);
			end
		end
		return res;
	endfunction

	// ----------------------------------------------------------------
	// request decode onto the two cam instances
	// ----------------------------------------------------------------
	always_comb begin
		op      = req_valid ? req.op : l2dc_pkg::L2DC_NOP;
		col     = req.addr[l2dc_pkg::COL_MSB:l2dc_pkg::COL_LSB];
		a5      = req.addr[l2dc_pkg::A5_BIT];
		a4      = req.addr[l2dc_pkg::A4_BIT];
		// row bit 5 is the panel row's low bit; bits 4:0 the entry in the panel
		row     = {(IS_ICACHE ? req.repl_way[2] : a4), req.requesting_core_number,
			req.repl_way[1:0]};
		word    = '0;
		word[l2dc_pkg::IDX_LSB +: l2dc_pkg::IDX_W]     = req.l2_index;
		word[l2dc_pkg::L2WAY_LSB +: l2dc_pkg::L2WAY_W] = req.l2_way;
		word[l2dc_pkg::PAR_BIT] = req.parity;
		word[l2dc_pkg::VLD_BIT] = 1'b1;
		col_sel = 4'h1 << col;
		for (int i = 0; i < N; i++) begin
			rd_en[i]  = '0;
			wr_en[i]  = '0;
			cam_en[i] = '0;
			unique case (op)
				l2dc_pkg::L2DC_UPDATE: begin
					if (a5 == i[0]) wr_en[i] = col_sel;
				end
				l2dc_pkg::L2DC_READ: begin
					if (a5 == i[0]) rd_en[i] = col_sel;
				end
				l2dc_pkg::L2DC_STORE_CAM: begin
					if (a5 == i[0]) cam_en[i] = col_sel;
				end
				l2dc_pkg::L2DC_EVICT_CAM: begin
					cam_en[i] = col_sel;
				end
				l2dc_pkg::L2DC_NOP, l2dc_pkg::L2DC_INVAL: begin
				end
			endcase
		end
		for (int s = 0; s < S; s++) begin
			mask[s] = (op == l2dc_pkg::L2DC_INVAL) ? last_match_clear_mask : '0;
		end
	end

	// ----------------------------------------------------------------
	// cam instances: instance index is address bit 5
	// ----------------------------------------------------------------
	for (genvar g = 0; g < N; g++) begin : g_cam
		l2dc_cam u_cam (
			.sys_clk                      (sys_clk),
			.srst                         (srst),
			.ce                           (ce),
			.rd_en                        (rd_en[g]),
			.wr_en                        (wr_en[g]),
			.cam_en                       (cam_en[g]),
			.force_hit                    ({S{force_hit}}),
			.sub_array_row_address        (row),
			.sub_array_write_compare_word (word),
			.last_match_clear_mask        (mask),
			.warm_rst                     (warm_rst),
			.row_hit                      (hit_w[g]),
			.sub_array_read_word          (rd_w[g])
		);
	end

	// ----------------------------------------------------------------
	// stage the request beside the cam cycle
	// ----------------------------------------------------------------
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			op_r  <= l2dc_pkg::L2DC_NOP;
			a5_r  <= 1'b0;
			a4_r  <= 1'b0;
			col_r <= 2'h0;
		end else if (ce) begin
			op_r  <= op;
			a5_r  <= a5;
			a4_r  <= a4;
			col_r <= col;
		end
	end

	// ----------------------------------------------------------------
	// hit rows to per-core invalidation vectors
	// ----------------------------------------------------------------
	always_comb begin
		store_cand = '0;
		evict_cand = '0;
		for (int i = 0; i < N; i++) begin
			for (int r = 0; r < R; r++) begin
				automatic int c  = (r >> 2) & 7;
				automatic int w  = r & 3;
				automatic int r5 = (r >> 5) & 1;
				if (IS_ICACHE) begin
					if (i == int'(a5_r)) begin
						store_cand[c][r5 * 4 + w] |= hit_w[i][r];
					end
					evict_cand[c * 2 + i][r5 * 4 + w] |= hit_w[i][r];
				end else begin
					if (i == int'(a5_r) && r5 == int'(a4_r)) begin
						store_cand[c][w] |= hit_w[i][r];
					end
					evict_cand[c * 4 + i * 2 + r5][w] |= hit_w[i][r];
				end
			end
		end
		for (int c = 0; c < l2dc_pkg::STORE_W; c++) begin
			store_nxt[c] = first_hit(store_cand[c]);
		end
		for (int l = 0; l < l2dc_pkg::EVICT_W; l++) begin
			evict_nxt[l] = first_hit(evict_cand[l]);
		end
	end

	always_ff @(posedge sys_clk) begin
		if (srst) begin
			result_valid <= 1'b0;
			store_vec    <= '0;
			evict_vec    <= '0;
		end else if (ce) begin
			result_valid <= (op_r == l2dc_pkg::L2DC_STORE_CAM) ||
				(op_r == l2dc_pkg::L2DC_EVICT_CAM) || (op_r == l2dc_pkg::L2DC_READ);
			if (op_r == l2dc_pkg::L2DC_STORE_CAM) begin
				store_vec <= store_nxt;
				evict_vec <= '0;
			end else if (op_r == l2dc_pkg::L2DC_EVICT_CAM) begin
				store_vec <= '0;
				evict_vec <= evict_nxt;
			end
		end
	end

	always_ff @(posedge sys_clk) begin
		if (srst) begin
			sub_array_read_word <= l2dc_pkg::WORD_RST;
		end else if (ce && op_r == l2dc_pkg::L2DC_READ) begin
			sub_array_read_word <= rd_w[a5_r][col_r];
		end
	end

endmodule // l2dc_dir

// ### bench/l2dc_dir_props.sv
`timescale 1ns/1ps
module l2dc_dir_props (
	input wire logic                                        sys_clk,
	input wire logic                                        srst,
	input wire logic                                        ce,
	input wire logic                                        req_valid,
	input wire l2dc_pkg::l2dc_req_s                         req,
	input wire logic                                        force_hit,
	input wire logic [1:0]                                  warm_rst,
	input wire logic                                        result_valid,
	input wire l2dc_pkg::l2dc_line_s [l2dc_pkg::STORE_W-1:0] store_vec,
	input wire l2dc_pkg::l2dc_line_s [l2dc_pkg::EVICT_W-1:0] evict_vec,
	input wire logic [l2dc_pkg::WORD_W-1:0]                 sub_array_read_word
);
	logic st_ask;
	logic ev_ask;
	logic rd_ask;
	logic ask;
	logic st_hit;
	assign st_ask = ce && req_valid && req.op == l2dc_pkg::L2DC_STORE_CAM;
	assign ev_ask = ce && req_valid && req.op == l2dc_pkg::L2DC_EVICT_CAM;
	assign rd_ask = ce && req_valid && req.op == l2dc_pkg::L2DC_READ;
	assign ask = st_ask || ev_ask || rd_ask;
	always_comb begin
		st_hit = 1'b0;
		for (int i = 0; i < l2dc_pkg::STORE_W; i++)
			st_hit = st_hit | store_vec[i].hit;
	end
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (srst);
	sequence s_wait;
		ce ##1 ce;
	endsequence
	sequence s_forced;
		force_hit ##1 force_hit;
	endsequence
	AST_RES_LAT: assert property (ask ##0 s_wait |=> result_valid)
		else $error("result pulse missing");
	AST_NO_SPUR: assert property (result_valid |-> $past(ask, 2))
		else $error("result pulse without request");
	AST_READ_HOLD: assert property ($changed(sub_array_read_word) |-> $past(rd_ask, 2))
		else $error("read word changed without read");
	AST_ST_CLR_EV: assert property (result_valid && $past(st_ask, 2) |-> evict_vec == '0)
		else $error("store result left eviction vector");
	AST_EV_CLR_ST: assert property (result_valid && $past(ev_ask, 2) |-> store_vec == '0)
		else $error("eviction result left store vector");
	AST_VEC_HOLD: assert property (!result_valid |-> $stable(store_vec) && $stable(evict_vec))
		else $error("vector changed without result");
	AST_FORCE: assert property ((st_ask && force_hit) ##0 s_forced |=> !st_hit)
		else $error("forced compare reported a hit");
	AST_WARM: assert property ((warm_rst == 2'h3) ##1 (st_ask && warm_rst == 2'h0) ##1 1'b1
		|=> !st_hit)
		else $error("hit after warm reset");
	AST_RST_OUT: assert property (disable iff (1'b0) srst |=> !result_valid && store_vec == '0
		&& evict_vec == '0 && sub_array_read_word == '0)
		else $error("outputs not cleared by reset");
endmodule // l2dc_dir_props

bind l2dc_dir l2dc_dir_props l2dc_dir_props_inst (
	.sys_clk(sys_clk), .srst(srst), .ce(ce), .req_valid(req_valid), .req(req),
	.force_hit(force_hit), .warm_rst(warm_rst), .result_valid(result_valid),
	.store_vec(store_vec), .evict_vec(evict_vec), .sub_array_read_word(sub_array_read_word)
);

// ### bench/l2dc_ctl_model.sv
`timescale 1ns/1ps
module l2dc_ctl_model (
	input  wire logic          sys_clk,
	output logic               req_valid,
	output l2dc_pkg::l2dc_req_s req
);
	initial begin
		req_valid = 1'b0;
		req = '0;
	end
	// one operation per cycle, so no write with compare or read
	task automatic send(input l2dc_pkg::l2dc_op_e op, input logic [6:0] a,
		input logic [2:0] c, input logic [2:0] w, input logic [12:0] k);
		req_valid = 1'b1;
		req.op = op;
		req.addr = a;
		req.requesting_core_number = c;
		req.repl_way = w;
		req.l2_index = k[8:0];
		req.l2_way = k[12:9];
		req.parity = ^k;
		@(negedge sys_clk);
	endtask
	// released request lines show the inverted last value, not the last value
	task automatic quiet();
		req_valid = 1'b0;
		req = ~req;
	endtask
endmodule // l2dc_ctl_model

// ### bench/l2_bank_l1_directory_cam_bench.sv
`timescale 1ns/1ps
module l2_bank_l1_directory_cam_bench;
	logic                sys_clk = 1'b0;
	logic                srst = 1'b1;
	logic                ce = 1'b1;
	logic                force_hit = 1'b0;
	logic [1:0]          warm_rst = 2'h0;
	logic [7:0]          mask = 8'hFF;
	logic                req_valid;
	l2dc_pkg::l2dc_req_s req;
	logic                result_valid;
	logic [31:0]         store_vec;
	logic [127:0]        evict_vec;
	logic [15:0]         rd_word;
	logic                result_valid_i;
	logic [31:0]         store_vec_i;
	logic [127:0]        evict_vec_i;
	logic [15:0]         rd_word_i;
	logic [12:0]         m_key [512];
	logic                m_v [512];
	int                  wq [$];
	int                  bad_count = 0;
	int                  compares = 0;
	int                  cyc = 0;
	int                  seed = 32'h3821;
	int                  j;
	always #2 sys_clk = ~sys_clk;
	l2dc_ctl_model l2dc_ctl_model_inst (.sys_clk(sys_clk), .req_valid(req_valid), .req(req));
	l2dc_dir #(.IS_ICACHE(1'b0)) l2dc_dir_inst (
		.sys_clk(sys_clk), .srst(srst), .ce(ce), .req_valid(req_valid), .req(req),
		.last_match_clear_mask(mask), .force_hit(force_hit), .warm_rst(warm_rst),
		.result_valid(result_valid), .store_vec(store_vec), .evict_vec(evict_vec),
		.sub_array_read_word(rd_word));
	// instruction-side directory on the same request stream
	if (1) begin : g_icache
		l2dc_dir #(.IS_ICACHE(1'b1)) l2dc_dir_inst (
			.sys_clk(sys_clk), .srst(srst), .ce(ce), .req_valid(req_valid), .req(req),
			.last_match_clear_mask(mask), .force_hit(force_hit), .warm_rst(warm_rst),
			.result_valid(result_valid_i), .store_vec(store_vec_i),
			.evict_vec(evict_vec_i), .sub_array_read_word(rd_word_i));
	end
	function automatic int ix(logic [6:0] a, logic [2:0] c, logic [1:0] w);
		return int'({a[6:5], a[1:0], c, w});
	endfunction
	function automatic logic [6:0] adr(int i);
		return {i[8:7], 3'($random(seed)), i[6:5]};
	endfunction
	function automatic logic [127:0] expect_vec(bit ev, logic [6:0] a, logic [12:0] k);
		logic [127:0] r;
		r = '0;
		for (int c = 0; c < 8; c++)
			for (int p = 0; p < 4; p++)
				for (int w = 3; w >= 0; w--)
					if ((ev || p == int'(a[1:0])) && m_v[ix({a[6:2], 2'(p)}, 3'(c), 2'(w))]
						&& m_key[ix({a[6:2], 2'(p)}, 3'(c), 2'(w))] === k)
						r[(ev ? c * 4 + p : c) * 4 +: 4] = {2'h2, 2'(w)};
		return r;
	endfunction
	task automatic chk(string n, logic [127:0] e, logic [127:0] g);
		compares++;
		if (e !== g) begin
			bad_count++;
			$display("[ERR] %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic wait_res();
		int n;
		n = 0;
		while (result_valid !== 1'b1 && n < 8) begin
			@(negedge sys_clk);
			n++;
		end
		if (n == 8) chk("result_valid", 1, 0);
	endtask
	task automatic cam(bit ev, logic [6:0] a, logic [12:0] k, bit inv);
		logic [127:0] e;
		e = force_hit ? '0 : expect_vec(ev, a, k);
		l2dc_ctl_model_inst.send(ev ? l2dc_pkg::L2DC_EVICT_CAM : l2dc_pkg::L2DC_STORE_CAM,
			a, 3'h0, 3'h0, k);
		if (inv) l2dc_ctl_model_inst.send(l2dc_pkg::L2DC_INVAL, a, 3'h0, 3'h0, k);
		l2dc_ctl_model_inst.quiet();
		wait_res();
		if (ev) chk("evict_vec", e, evict_vec);
		else chk("store_vec", e, 128'(store_vec));
	endtask
	task automatic rd(logic [6:0] a, logic [2:0] c, logic [1:0] w);
		int i;
		i = ix(a, c, w);
		l2dc_ctl_model_inst.send(l2dc_pkg::L2DC_READ, a, c, {1'b0, w}, 13'h0);
		l2dc_ctl_model_inst.quiet();
		wait_res();
		chk("read_word", 128'({m_v[i], ^m_key[i], 1'b0, m_key[i]}), 128'(rd_word));
	endtask
	task automatic go(l2dc_pkg::l2dc_op_e op, logic [6:0] a, logic [2:0] c, logic [2:0] w,
		logic [12:0] k);
		l2dc_ctl_model_inst.send(op, a, c, w, k);
		l2dc_ctl_model_inst.quiet();
		wait_res();
	endtask
	task automatic upd(logic [6:0] a, logic [2:0] c, logic [1:0] w, logic [12:0] k);
		l2dc_ctl_model_inst.send(l2dc_pkg::L2DC_UPDATE, a, c, {1'b0, w}, k);
		m_v[ix(a, c, w)] = 1'b1;
		m_key[ix(a, c, w)] = k;
		wq.push_back(ix(a, c, w));
		rd(a, c, w);
	endtask
	task automatic end_sim();
		$display("compares %0d mismatches %0d", compares, bad_count);
		if (bad_count == 0 && compares > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask
	always @(posedge sys_clk) begin
		cyc++;
		if (cyc == 20000) begin
			bad_count++;
			end_sim();
		end
	end
	initial begin
		for (int i = 0; i < 512; i++) begin
			m_v[i] = 1'b0;
			m_key[i] = 13'h0;
		end
		repeat (12) @(negedge sys_clk);
		srst = 1'b0;
		for (int i = 0; i < 48; i++)
			upd(7'($random(seed)), 3'($random(seed)), 2'($random(seed)),
				13'($random(seed)) & 13'h0603);
		$display("test update and read done");
		for (int i = 0; i < 60; i++) begin
			j = wq[unsigned'($random(seed)) % wq.size()];
			cam(i[0], adr(j), (i % 3 == 0) ? 13'($random(seed)) & 13'h0603 : m_key[j], 0);
		end
		$display("test store and eviction compares done");
		force_hit = 1'b1;
		cam(0, adr(j), m_key[j], 0);
		force_hit = 1'b0;
		$display("test forced match done");
		warm_rst = 2'h1;
		@(negedge sys_clk);
		warm_rst = 2'h0;
		for (int i = 0; i < 256; i++) m_v[i] = 1'b0;
		for (int i = 0; i < 8; i++) begin
			j = wq[unsigned'($random(seed)) % wq.size()];
			cam(1, adr(j), m_key[j], 0);
		end
		$display("test partial warm reset done");
		warm_rst = 2'h3;
		@(negedge sys_clk);
		warm_rst = 2'h0;
		for (int i = 0; i < 512; i++) m_v[i] = 1'b0;
		cam(0, 7'h21, 13'h0AAA, 0);
		for (int c = 0; c < 5; c++) upd(7'h21, 3'(c), 2'h0, (c == 4) ? 13'h0155 : 13'h0AAA);
		// only rows 32..39 cleared: cores 0 and 1
		mask = 8'h10;
		cam(0, 7'h21, 13'h0AAA, 1);
		for (int c = 0; c < 2; c++) m_v[ix(7'h21, 3'(c), 2'h0)] = 1'b0;
		rd(7'h21, 3'h0, 2'h0);
		cam(0, 7'h21, 13'h0AAA, 0);
		cam(0, 7'h21, 13'h0155, 0);
		$display("test invalidate done");
		warm_rst = 2'h3;
		@(negedge sys_clk);
		warm_rst = 2'h0;
		l2dc_ctl_model_inst.send(l2dc_pkg::L2DC_UPDATE, 7'h02, 3'h3, 3'h5, 13'h0123);
		l2dc_ctl_model_inst.send(l2dc_pkg::L2DC_UPDATE, 7'h00, 3'h3, 3'h6, 13'h0123);
		l2dc_ctl_model_inst.send(l2dc_pkg::L2DC_UPDATE, 7'h02, 3'h5, 3'h2, 13'h0456);
		go(l2dc_pkg::L2DC_STORE_CAM, 7'h02, 3'h0, 3'h0, 13'h0123);
		chk("result_valid_i", 128'h1, 128'(result_valid_i));
		chk("store_vec_i", 128'h0000D000, 128'(store_vec_i));
		go(l2dc_pkg::L2DC_EVICT_CAM, 7'h00, 3'h0, 3'h0, 13'h0123);
		chk("evict_vec_i", 128'hDE000000, evict_vec_i);
		go(l2dc_pkg::L2DC_READ, 7'h02, 3'h3, 3'h5, 13'h0);
		chk("read_word_i", 128'h8123, 128'(rd_word_i));
		$display("test instruction directory done");
		// let the read pulse fall before freezing
		@(negedge sys_clk);
		ce = 1'b0;
		l2dc_ctl_model_inst.send(l2dc_pkg::L2DC_UPDATE, 7'h02, 3'h3, 3'h5, 13'h0456);
		ce = 1'b1;
		go(l2dc_pkg::L2DC_READ, 7'h02, 3'h3, 3'h5, 13'h0);
		chk("read_word_i", 128'h8123, 128'(rd_word_i));
		$display("test clock enable done");
		end_sim();
	end
endmodule // l2_bank_l1_directory_cam_bench
